// file: low_power_mode_control.v
// Low-power mode controller: halt, idle and slow modes
`default_nettype none
`include "lpm_map.vh"
// Behaviour
// (RULE1) Halt mode stops the oscillator and all internal processing.
// (RULE2) Only external interrupt or reset wakes halt mode.
// (RULE3) Entering halt clears the interrupt mask bit.
// (RULE4) Entering halt clears the slow mode bit.
// (RULE5) Halt keeps registers, memory and I/O lines unchanged.
// (RULE6) Halt wake vectors to interrupt or reset vector pair.
// (RULE7) Leaving halt holds the CPU 16 or 4064 cycles, option selected.
// (RULE8) After the delay CPU services the waking interrupt or reset vector.
// (RULE9) Interrupt stacking for halt wake happens only on leaving halt.
// (RULE10) Halt resets watchdog, stops timer, serial, converter; memory read-only.
// (RULE11) Idle suspends CPU; timer, converter and serial keep running.
// (RULE12) Idle leaves memory programming, charge pump, registers and I/O alone.
// (RULE13) Entering idle clears the interrupt mask bit.
// (RULE14) Entering idle leaves the external interrupt enable bit unchanged.
// (RULE15) Idle ends on external, timer or serial interrupt or reset pin.
// (RULE16) Non-reset idle exit keeps state; reset exit restores reset state.
// (RULE17) Interrupt stacking for idle wake happens only on leaving idle.
// (RULE18) Timer keeps running in idle and cannot be disabled.
// (RULE19) Slow mode bit adds a divide-by-16 before the clock driver.
// (RULE20) Software avoids slow mode during conversion or programming without RC.
// (RULE21) Bus clock is oscillator over 32 in slow mode, else over 2.
// (RULE22) Slow mode bit is cleared by external and power-on reset.
// (RULE23) Stabilisation counter on the restarted oscillator gates the CPU clock.
module low_power_mode_control (
  input wire core_clk, // Oscillator clock, 40 MHz
  input wire rst, // Power-on or external reset, async
  input wire long_delay_opt, // Option strap: 1 selects 4064-cycle delay
  input wire wdog_idle_run_opt, // Option strap: watchdog runs in idle
  input wire halt_req, // CPU executes stop instruction, pulse
  input wire idle_req, // CPU executes wait instruction, pulse
  input wire ext_irq_n, // External interrupt pin, active low, async
  input wire timer_irq, // Timer interrupt request
  input wire serial_irq, // Serial interface interrupt request
  input wire [7:0] addr, // Register address
  input wire [7:0] wdata, // Register write data
  input wire wr, // Register write strobe
  input wire rd, // Register read strobe
  output reg [7:0] rdata, // Register read data, one cycle after rd
  output reg osc_run, // Oscillator enable
  output reg cpu_clk_en, // CPU clock gate
  output reg bus_tick, // Bus clock tick
  output reg periph_run, // Timer, serial and converter clock enable
  output reg wdog_clear, // Watchdog reset request
  output reg wdog_run, // Watchdog clock enable
  output reg nvm_read_only, // Nonvolatile memory forced read-only
  output reg conv_disable, // Converter disabled
  output reg pwm_hold, // Pulse-length modulator outputs hold
  output reg io_hold, // I/O lines hold state
  output reg clear_int_mask, // Pulse: clear condition code register mask bit
  output reg stack_req, // Pulse: stack and service the waking interrupt
  output reg [15:0] vector_addr, // Vector address to fetch
  output reg vector_fetch, // Pulse: fetch vector_addr
  output reg slow_mode_bit, // Slow mode bit
  output reg ext_interrupt_enable_bit, // External interrupt enable bit
  output reg [3:0] mode_state // Current state, one-hot
);
  localparam [3:0] ST_RUN = 4'b0001;
  localparam [3:0] ST_IDLE = 4'b0010;
  localparam [3:0] ST_HALT = 4'b0100;
  localparam [3:0] ST_STAB = 4'b1000;

  wire ext_irq_sync;
  wire div_tick;
  reg [3:0] state;
  reg [3:0] next_state;
  reg [11:0] stab_cnt;
  reg long_opt;
  reg wdog_opt;
  reg strap_taken;
  reg from_reset;

  sync2 irq_sync (
    .clk(core_clk),
    .rst(rst),
    .d(~ext_irq_n),
    .q(ext_irq_sync)
  );

  // Divider stops with the oscillator so halt freezes all processing
  bus_clk_div divider (
    .clk(core_clk),
    .rst(rst),
    .run(state != ST_HALT),
    .slow(slow_mode_bit),
    .tick(div_tick)
  ); // RULE19 RULE21

  wire ext_wake = ext_irq_sync & ext_interrupt_enable_bit;
  wire idle_wake = ext_wake | timer_irq | serial_irq; // RULE15
  wire [11:0] stab_limit = long_opt ? `STAB_LONG : `STAB_SHORT;

  // Straps caught once after reset release, never under reset itself
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      strap_taken <= 1'b0;
      long_opt <= 1'b1;
      wdog_opt <= 1'b0;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      long_opt <= long_delay_opt;
      wdog_opt <= wdog_idle_run_opt;
    end
  end

  always @* begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (halt_req) begin
          next_state = ST_HALT;
        end else if (idle_req) begin
          next_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (idle_wake) begin
          next_state = ST_RUN; // RULE15
        end
      end
      ST_HALT: begin
        if (ext_wake) begin
          next_state = ST_STAB; // RULE2
        end
      end
      ST_STAB: begin
        if (stab_cnt >= stab_limit - 12'd1) begin
          next_state = ST_RUN; // RULE7
        end
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= ST_RUN;
      stab_cnt <= 12'h000;
      from_reset <= 1'b1;
      slow_mode_bit <= 1'b0; // RULE22
      ext_interrupt_enable_bit <= 1'b1;
      clear_int_mask <= 1'b0;
      stack_req <= 1'b0;
      vector_fetch <= 1'b0;
      vector_addr <= `RESET_VECTOR;
    end else begin
      state <= next_state;
      clear_int_mask <= 1'b0;
      stack_req <= 1'b0;
      vector_fetch <= 1'b0;
      from_reset <= 1'b0;
      // Reset wake vectors after the system leaves reset
      if (from_reset) begin
        vector_fetch <= 1'b1;
        vector_addr <= `RESET_VECTOR; // RULE6 RULE8 RULE16
      end
      if (state == ST_STAB) begin
        stab_cnt <= stab_cnt + 12'd1; // RULE23
      end else begin
        stab_cnt <= 12'h000;
      end
      if (state == ST_RUN && wr && addr == `MISC_REG_ADDR) begin
        slow_mode_bit <= wdata[`SLOW_BIT];
        ext_interrupt_enable_bit <= wdata[`EXT_INT_EN_BIT];
      end
      if (state == ST_RUN && halt_req) begin
        clear_int_mask <= 1'b1; // RULE3
        slow_mode_bit <= 1'b0; // RULE4
      end else if (state == ST_RUN && idle_req) begin
        clear_int_mask <= 1'b1; // RULE13 RULE14
      end
      // Stacking deferred to the exit edge
      if (state == ST_STAB && next_state == ST_RUN) begin
        stack_req <= 1'b1; // RULE9 RULE8
        vector_fetch <= 1'b1;
        vector_addr <= `IRQ_VECTOR; // RULE6
      end
      if (state == ST_IDLE && idle_wake) begin
        stack_req <= 1'b1; // RULE17 RULE16
      end
    end
  end

  // Module side effects, all registered
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      osc_run <= 1'b1;
      cpu_clk_en <= 1'b0;
      bus_tick <= 1'b0;
      periph_run <= 1'b0;
      wdog_clear <= 1'b1;
      wdog_run <= 1'b0;
      nvm_read_only <= 1'b0;
      conv_disable <= 1'b1;
      pwm_hold <= 1'b0;
      io_hold <= 1'b0;
      mode_state <= ST_RUN;
      rdata <= 8'h00;
    end else begin
      mode_state <= next_state;
      osc_run <= (next_state != ST_HALT); // RULE1
      cpu_clk_en <= (next_state == ST_RUN) & div_tick; // RULE11 RULE23
      bus_tick <= div_tick;
      periph_run <= (next_state == ST_RUN || next_state == ST_IDLE) & div_tick; // RULE18 RULE1
      wdog_clear <= (next_state == ST_HALT); // RULE10
      wdog_run <= (next_state == ST_RUN) | ((next_state == ST_IDLE) & wdog_opt); // RULE11
      nvm_read_only <= (next_state == ST_HALT); // RULE10 RULE12
      conv_disable <= (next_state == ST_HALT); // RULE10
      pwm_hold <= (next_state == ST_HALT); // RULE10
      io_hold <= (next_state == ST_HALT) | (next_state == ST_IDLE); // RULE5 RULE12
      if (rd && addr == `MISC_REG_ADDR) begin
        rdata <= 8'h00 | ({7'h00, slow_mode_bit} << `SLOW_BIT)
                 | {7'h00, ext_interrupt_enable_bit};
      end else begin
        rdata <= 8'h00;
      end
    end
  end
endmodule // low_power_mode_control
`default_nettype wire

// file: lpm_map.vh
// Constants for the low-power mode controller
`ifndef LPM_MAP_VH
`define LPM_MAP_VH
`define MISC_REG_ADDR 8'h0C
`define SLOW_BIT 1
`define EXT_INT_EN_BIT 0
`define MISC_RESET 8'h00
`define IRQ_VECTOR 16'h1FFA
`define RESET_VECTOR 16'h1FFE
`define STAB_SHORT 12'd16
`define STAB_LONG 12'd4064
`define NORMAL_DIV 6'd2
`define SLOW_DIV 6'd32
`define SLOW_EXTRA_DIV 16
`endif

// file: sync2.v
// Two-flop synchroniser for one level
`default_nettype none
module sync2 (
  input wire clk, // Clock
  input wire rst, // Async reset
  input wire d, // Asynchronous level
  output reg q // Synchronised level
);
  reg meta;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= 1'b0;
      q <= 1'b0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // sync2
`default_nettype wire

// file: bus_clk_div.v
// Bus clock enable divider, divide by 2 or 32
`default_nettype none
`include "lpm_map.vh"
module bus_clk_div (
  input wire clk, // Oscillator clock
  input wire rst, // Async reset
  input wire run, // Divider runs when high
  input wire slow, // Slow mode selects the longer division
  output reg tick // One-cycle bus clock tick
);
  reg [5:0] cnt;
  wire [5:0] limit = slow ? `SLOW_DIV : `NORMAL_DIV;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 6'h00;
      tick <= 1'b0;
    end else if (!run) begin
      cnt <= 6'h00;
      tick <= 1'b0;
    end else if (cnt >= limit - 6'd1) begin
      cnt <= 6'h00;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 6'd1;
      tick <= 1'b0;
    end
  end
endmodule // bus_clk_div
`default_nettype wire

// file: low_power_mode_control_asserts.sv
// Checker for the low-power mode controller
`default_nettype none
module lpm_checker (
  input wire logic core_clk, // Clock
  input wire logic rst, // Reset
  input wire logic long_delay_opt, // Strap
  input wire logic halt_req, // Stop
  input wire logic idle_req, // Wait
  input wire logic timer_irq, // Timer
  input wire logic osc_run, // Osc
  input wire logic clear_int_mask, // Mask
  input wire logic stack_req, // Stack
  input wire logic [15:0] vector_addr, // Vector
  input wire logic vector_fetch, // Fetch
  input wire logic slow_mode_bit, // Slow
  input wire logic ext_interrupt_enable_bit, // Enable
  input wire logic [3:0] mode_state // State
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  logic [12:0] stab_n;
  // Cycles spent in the settling state
  always_ff @(posedge core_clk or posedge rst)
    if (rst) stab_n <= 13'h0000;
    else stab_n <= mode_state[3] ? stab_n + 13'h0001 : 13'h0000;
  halt_enter_a: assert property (halt_req && mode_state == 4'h1 |=>
    mode_state == 4'h4 && !osc_run && clear_int_mask && !slow_mode_bit) else $error("bad halt");
  halt_stay_a: assert property (mode_state == 4'h4 |=> mode_state[2] || mode_state[3])
    else $error("halt left wrongly");
  stab_delay_a: assert property ($fell(mode_state[3]) |->
    stab_n >= (long_delay_opt ? 13'h0FE0 : 13'h0010) &&
    stab_n <= (long_delay_opt ? 13'h0FE2 : 13'h0012)) else $error("bad delay");
  halt_vector_a: assert property (vector_fetch && $past(mode_state[3]) |->
    vector_addr == 16'h1FFA && stack_req) else $error("bad wake vector");
  idle_enter_a: assert property (idle_req && !halt_req && mode_state == 4'h1 |=>
    mode_state == 4'h2 && clear_int_mask) else $error("bad idle entry");
  idle_ext_interrupt_enable_bit_a: assert property (idle_req && mode_state == 4'h1 |=>
    $stable(ext_interrupt_enable_bit)) else $error("enable bit moved");
  idle_exit_a: assert property (timer_irq && mode_state == 4'h2 |=>
    stack_req && mode_state == 4'h1) else $error("bad idle exit");
  stack_only_a: assert property (stack_req |->
    $past(mode_state[1]) || $past(mode_state[3])) else $error("early stacking");
endmodule // lpm_checker
bind low_power_mode_control lpm_checker chk_i (.core_clk, .rst, .long_delay_opt,
  .halt_req, .idle_req, .timer_irq, .osc_run, .clear_int_mask, .stack_req, .vector_addr,
  .vector_fetch, .slow_mode_bit, .ext_interrupt_enable_bit, .mode_state);
`default_nettype wire

// file: cpu_periph_model.sv
// Timer and interrupt pin model on the far side
`default_nettype none
module cpu_periph_model (
  input wire logic core_clk, // Clock
  input wire logic rst, // Reset
  input wire logic periph_run, // Timer tick
  input wire logic stack_req, // Interrupt taken
  input wire logic irq_cmd, // Pull pin low
  output logic ext_irq_n, // Pin, pulled up
  output logic timer_irq // Overflow
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] tcnt;
  // Timer only advances on ticks, so a stopped clock freezes it
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tcnt <= 4'h0;
      timer_irq <= 1'b0;
      ext_irq_n <= 1'b1;
    end else begin
      if (periph_run) tcnt <= tcnt + 4'h1;
      if (periph_run && tcnt == 4'hF) timer_irq <= 1'b1;
      else if (stack_req) timer_irq <= 1'b0;
      if (irq_cmd) ext_irq_n <= 1'b0;
      else if (stack_req) ext_irq_n <= 1'b1;
    end
  end
endmodule // cpu_periph_model
`default_nettype wire

// file: low_power_mode_control_test.sv
// Self-checking bench for the low-power mode controller
`default_nettype none
module low_power_mode_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, rst = 1, long_delay_opt = 0, halt_req = 0, idle_req = 0;
  logic wr = 0, rd = 0, irq_cmd = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00;
  wire [7:0] rdata;
  wire [15:0] vector_addr;
  wire [3:0] mode_state;
  wire ext_irq_n, timer_irq, osc_run, bus_tick, periph_run, wdog_clear, nvm_read_only;
  wire conv_disable, pwm_hold, io_hold, clear_int_mask, stack_req, vector_fetch;
  wire slow_mode_bit, ext_interrupt_enable_bit, cpu_clk_en, wdog_run;
  int n_errors = 0, comparisons = 0, cyc = 0, n, nb, np;
  logic [15:0] rows [4] = '{16'h0000, 16'h0202, 16'h0101, 16'hFF03};
  low_power_mode_control uut (.core_clk, .rst, .long_delay_opt, .wdog_idle_run_opt(1'b0),
    .halt_req, .idle_req, .ext_irq_n, .timer_irq, .serial_irq(1'b0), .addr, .wdata, .wr,
    .rd, .rdata, .osc_run, .cpu_clk_en, .bus_tick, .periph_run, .wdog_clear,
    .wdog_run, .nvm_read_only, .conv_disable, .pwm_hold, .io_hold, .clear_int_mask,
    .stack_req, .vector_addr, .vector_fetch, .slow_mode_bit, .ext_interrupt_enable_bit,
    .mode_state);
  cpu_periph_model far (.core_clk, .rst, .periph_run, .stack_req, .irq_cmd, .ext_irq_n,
    .timer_irq);
  initial forever #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      end_of_test;
    end
  end
  task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk) wr <= 1'b0;
  endtask
  task rd_chk(input logic [7:0] a, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk) rd <= 1'b0;
    @(negedge core_clk) chk("rdata", 16'(rdata), 16'(e));
    @(posedge core_clk);
  endtask
  task cnt(input int c);
    nb = 0;
    np = 0;
    repeat (c) @(negedge core_clk) begin
      nb += int'(bus_tick);
      np += int'(periph_run);
    end
    @(posedge core_clk);
  endtask
  task rst_seq;
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    @(negedge core_clk) chk("reset fetch", {vector_addr[14:0], vector_fetch}, 16'h3FFD);
    chk("reset bits", {slow_mode_bit, ext_interrupt_enable_bit, mode_state}, 16'h0011);
    @(posedge core_clk);
    $display("test reset done");
  endtask
  task do_halt;
    halt_req <= 1'b1;
    @(posedge core_clk) halt_req <= 1'b0;
    @(negedge core_clk) chk("halt entry", {slow_mode_bit, clear_int_mask}, 16'h0001);
    // Last divider tick before halt may still reach bus_tick
    @(posedge core_clk);
    cnt(40);
    chk("halt gates", {cpu_clk_en, wdog_run}, 16'h0000);
    chk("halt ticks", 16'(nb + np), 16'h0000);
    chk("halt levels", {mode_state, osc_run, io_hold, nvm_read_only, pwm_hold, conv_disable,
      wdog_clear}, 16'h011F);
    irq_cmd <= 1'b1;
    @(posedge core_clk) irq_cmd <= 1'b0;
    n = 0;
    while (vector_fetch !== 1'b1 && n < 5000) begin
      @(negedge core_clk);
      n++;
    end
    chk("wake", {vector_addr[11:0], stack_req, mode_state[2:0]}, 16'hFFA9);
    @(posedge core_clk);
    $display("test halt done");
  endtask
  task end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    rst_seq;
    foreach (rows[i]) begin
      wr_reg(8'h0C, rows[i][15:8]);
      rd_chk(8'h0C, rows[i][7:0]);
    end
    rd_chk(8'h0D, 8'h00);
    cnt(40);
    cnt(64);
    chk("slow ticks", 16'(nb), 16'h0002);
    wr_reg(8'h0C, 8'h01);
    cnt(40);
    cnt(64);
    chk("fast ticks", 16'(nb), 16'h0020);
    $display("test registers done");
    wr_reg(8'h0C, 8'h03);
    do_halt;
    wr_reg(8'h0C, 8'h03);
    long_delay_opt <= 1'b1;
    rst_seq;
    do_halt;
    idle_req <= 1'b1;
    @(posedge core_clk) idle_req <= 1'b0;
    @(negedge core_clk) chk("idle", {mode_state, clear_int_mask}, 16'h0005);
    n = 0;
    while (stack_req !== 1'b1 && n < 200) begin
      @(negedge core_clk);
      n++;
    end
    chk("idle exit", {mode_state, stack_req, vector_fetch}, 16'h0006);
    @(posedge core_clk);
    rd_chk(8'h0C, 8'h01);
    idle_req <= 1'b1;
    @(posedge core_clk) idle_req <= 1'b0;
    rst_seq;
    $display("test idle done");
    end_of_test;
  end
endmodule // low_power_mode_control_test
`default_nettype wire
